// *** design/char_lcd_host_port.sv ***
// Host bus port of a 16x2 character display controller: strobed parallel pins,
// display and glyph memories, a command register and an Avalon-MM register slave.
// Assumes pins synchronous to mclk and a strobe held for several mclk cycles.
//
// Behaviour
// - A write with register_select low takes the host byte as a command.
// - A read with register_select low returns the busy flag and the address counter.
// - With register_select high the access reaches the data register, for reads and writes.
// - read_not_write low means the host writes, high means the host reads.
// - Every transfer is started by the strobe; select and direction act only with it.
// - On a status read the top data line carries the busy indication.
// - In four-bit mode only the upper four data lines count and the lower four are ignored.
// - In four-bit mode a byte moves as upper nibble then lower nibble, complete after both.
// - In eight-bit mode a whole byte moves in one strobed transfer on all eight lines.
// - A host-writable glyph memory holds eight user patterns loaded by data writes.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
module char_lcd_host_port
	import char_lcd_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire host_pins_t pins,
	output logic [7:0] data_out,
	output logic data_oe,
	input wire avalon_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	localparam int LW = $clog2(DEPTH) + 1;

	typedef struct packed {
		logic [DISP_CELLS-1:0][7:0] disp_mem;
		logic [GLYPH_WORDS-1:0][4:0] glyph_mem;
		logic [6:0] disp_addr;
		logic [5:0] glyph_addr;
		logic glyph_sel;
		logic eight_bit;
		logic phase;
		logic [3:0] high_nibble;
		logic strobe_q;
		logic push;
		logic [FIFO_WIDTH-1:0] push_data;
		logic [7:0] command;
		logic cmd_pending;
		logic overrun;
		logic [6:0] peek_addr;
		logic [7:0] data_out;
		logic data_oe;
		logic [31:0] readdata;
		logic waitrequest;
	} port_state_t;

	port_state_t s_q;
	port_state_t s_d;

	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FIFO_WIDTH-1:0] fifo_out_data;
	logic [LW-1:0] fifo_level;
	logic busy;
	logic drain_stall;
	logic [7:0] status_byte;
	logic [7:0] read_byte;
	logic strobe_rise;
	logic strobe_fall;
	logic [7:0] host_byte;

	// ==========================================================
	// Helpers
	function automatic logic disp_valid(input logic [6:0] a);
		disp_valid = (a <= ROW1_LAST) || ((a >= ROW2_FIRST) && (a <= ROW2_LAST));
	endfunction : disp_valid

	// Two rows of 40 cells packed into one 80-entry store
	function automatic logic [6:0] disp_index(input logic [6:0] a);
		disp_index = (a >= ROW2_FIRST) ? (a - ROW2_FIRST + ROW2_INDEX_BASE) : a;
	endfunction : disp_index

	function automatic logic [6:0] disp_next(input logic [6:0] a);
		if (a == ROW1_LAST) begin
			disp_next = ROW2_FIRST;
		end else if (a == ROW2_LAST) begin
			disp_next = ROW1_FIRST;
		end else begin
			disp_next = a + 7'h01;
		end
	endfunction : disp_next

	// ==========================================================
	// Host data queue
	// Commands and data share one queue so address changes keep their order
	char_lcd_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(s_q.push),
		.in_ready(fifo_in_ready),
		.in_data(s_q.push_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// A plain command waits while software has not taken the previous one
	assign drain_stall = fifo_out_data[8] && !fifo_out_data[CMD_DISP_ADDR_BIT]
		&& !fifo_out_data[CMD_GLYPH_ADDR_BIT] && s_q.cmd_pending;
	assign fifo_out_ready = !drain_stall;
	assign busy = fifo_out_valid || s_q.push;
	assign status_byte = {busy, (s_q.glyph_sel ? {1'b0, s_q.glyph_addr} : s_q.disp_addr)};

	always_comb begin
		read_byte = 8'h00;
		if (!pins.register_select) begin
			read_byte = status_byte;
		end else if (s_q.glyph_sel) begin
			read_byte = {3'h0, s_q.glyph_mem[s_q.glyph_addr]};
		end else if (disp_valid(s_q.disp_addr)) begin
			read_byte = s_q.disp_mem[disp_index(s_q.disp_addr)];
		end
	end

	assign strobe_rise = pins.strobe && !s_q.strobe_q;
	assign strobe_fall = !pins.strobe && s_q.strobe_q;
	// Lower lines are not looked at in four-bit mode
	assign host_byte = s_q.eight_bit ? pins.data : {s_q.high_nibble, pins.data[7:4]};

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.strobe_q = pins.strobe;
		s_d.push = 1'b0;

		// ==========================================================
		// Pin side
		if (strobe_rise && pins.read_not_write) begin
			s_d.data_oe = 1'b1;
			if (s_q.eight_bit) begin
				s_d.data_out = read_byte;
			end else if (!s_q.phase) begin
				s_d.data_out = {read_byte[7:4], 4'h0};
			end else begin
				s_d.data_out = {read_byte[3:0], 4'h0};
			end
		end
		if (strobe_fall) begin
			s_d.data_oe = 1'b0;
			if (!s_q.eight_bit && !s_q.phase) begin
				s_d.phase = 1'b1;
				s_d.high_nibble = pins.data[7:4];
			end else begin
				s_d.phase = 1'b0;
				if (!pins.read_not_write) begin
					// One byte done: command when select is low, data otherwise
					s_d.push = 1'b1;
					s_d.push_data = {!pins.register_select, host_byte};
				end else if (pins.register_select) begin
					if (s_q.glyph_sel) begin
						s_d.glyph_addr = s_q.glyph_addr + 6'h01;
					end else begin
						s_d.disp_addr = disp_next(s_q.disp_addr);
					end
				end
			end
		end
		// Host that ignores busy loses the byte; the overrun flag tells software
		if (s_q.push && !fifo_in_ready) begin
			s_d.overrun = 1'b1;
		end

		// ==========================================================
		// Queue drain
		if (fifo_out_valid && !drain_stall) begin
			if (fifo_out_data[8]) begin
				if (fifo_out_data[CMD_DISP_ADDR_BIT]) begin
					s_d.glyph_sel = 1'b0;
					s_d.disp_addr = fifo_out_data[6:0];
				end else if (fifo_out_data[CMD_GLYPH_ADDR_BIT]) begin
					s_d.glyph_sel = 1'b1;
					s_d.glyph_addr = fifo_out_data[5:0];
				end else begin
					s_d.command = fifo_out_data[7:0];
					s_d.cmd_pending = 1'b1;
				end
			end else if (s_q.glyph_sel) begin
				s_d.glyph_mem[s_q.glyph_addr] = fifo_out_data[4:0];
				s_d.glyph_addr = s_q.glyph_addr + 6'h01;
			end else begin
				if (disp_valid(s_q.disp_addr)) begin
					s_d.disp_mem[disp_index(s_q.disp_addr)] = fifo_out_data[7:0];
				end
				s_d.disp_addr = disp_next(s_q.disp_addr);
			end
		end

		// ==========================================================
		// Avalon slave: answer one cycle after the request, write on the ack edge
		s_d.waitrequest = 1'b1;
		if ((avs_req.read || avs_req.write) && s_q.waitrequest) begin
			s_d.waitrequest = 1'b0;
			s_d.readdata = 32'h0000_0000;
			if (avs_req.read) begin
				if (avs_req.address == OFS_CONTROL) begin
					s_d.readdata[CTL_EIGHT_BIT] = s_q.eight_bit;
				end else if (avs_req.address == OFS_STATUS) begin
					s_d.readdata[7:0] = status_byte;
					s_d.readdata[STA_CMD_PENDING] = s_q.cmd_pending;
					s_d.readdata[STA_FIFO_FULL] = !fifo_in_ready;
					s_d.readdata[STA_OVERRUN] = s_q.overrun;
					s_d.readdata[STA_GLYPH_SEL] = s_q.glyph_sel;
					s_d.readdata[STA_LEVEL_LSB +: LW] = fifo_level;
				end else if (avs_req.address == OFS_COMMAND) begin
					s_d.readdata[7:0] = s_q.command;
					s_d.readdata[CMD_CLEAR_BIT] = s_q.cmd_pending;
				end else if (avs_req.address == OFS_PEEK) begin
					s_d.readdata[14:8] = s_q.peek_addr;
					if (disp_valid(s_q.peek_addr)) begin
						s_d.readdata[7:0] = s_q.disp_mem[disp_index(s_q.peek_addr)];
					end
				end
			end
		end
		if (avs_req.write && !s_q.waitrequest) begin
			if (avs_req.address == OFS_CONTROL) begin
				s_d.eight_bit = avs_req.writedata[CTL_EIGHT_BIT];
				if (avs_req.writedata[CTL_PHASE_CLEAR]) begin
					s_d.phase = 1'b0;
				end
			end else if (avs_req.address == OFS_STATUS) begin
				if (avs_req.writedata[STA_OVERRUN] && !(s_q.push && !fifo_in_ready)) begin
					s_d.overrun = 1'b0;
				end
			end else if (avs_req.address == OFS_COMMAND) begin
				// A command arriving in the same cycle keeps the flag set
				if (avs_req.writedata[CMD_CLEAR_BIT] && !s_d.cmd_pending) begin
					s_d.cmd_pending = 1'b0;
				end else if (avs_req.writedata[CMD_CLEAR_BIT] && s_q.cmd_pending
					&& !(fifo_out_valid && !drain_stall && fifo_out_data[8])) begin
					s_d.cmd_pending = 1'b0;
				end
			end else if (avs_req.address == OFS_PEEK) begin
				s_d.peek_addr = avs_req.writedata[6:0];
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.eight_bit <= CTL_EIGHT_BIT_RESET;
			s_q.waitrequest <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_out = s_q.data_out;
	assign data_oe = s_q.data_oe;
	assign avs_readdata = s_q.readdata;
	assign avs_waitrequest = s_q.waitrequest;

endmodule : char_lcd_host_port

// *** design/char_lcd_pkg.sv ***
// Constants, register map and carrier types of the character display host port.
// Assumes a 40 MHz mclk and a 32-bit Avalon-MM slave with byte addresses.
package char_lcd_pkg;

	// ==========================================================
	// Clock and sizes
	localparam int CLK_MHZ = 40;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 9;
	localparam int GLYPH_CHARS = 8;
	localparam int GLYPH_ROWS = 8;
	localparam int GLYPH_WORDS = GLYPH_CHARS * GLYPH_ROWS;
	localparam int DISP_CELLS = 80;

	// ==========================================================
	// Display memory map
	localparam logic [6:0] ROW1_FIRST = 7'h00;
	localparam logic [6:0] ROW1_LAST = 7'h27;
	localparam logic [6:0] ROW2_FIRST = 7'h40;
	localparam logic [6:0] ROW2_LAST = 7'h67;
	localparam logic [6:0] ROW2_INDEX_BASE = 7'h28;

	// ==========================================================
	// Command byte decode
	localparam int CMD_DISP_ADDR_BIT = 7;
	localparam int CMD_GLYPH_ADDR_BIT = 6;

	// ==========================================================
	// Register map (byte offsets)
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_COMMAND = 4'h8;
	localparam logic [3:0] OFS_PEEK = 4'hC;

	// Control fields
	localparam int CTL_EIGHT_BIT = 0;
	localparam int CTL_PHASE_CLEAR = 1;
	localparam logic CTL_EIGHT_BIT_RESET = 1'b1;

	// Status fields
	localparam int STA_BUSY = 7;
	localparam int STA_CMD_PENDING = 8;
	localparam int STA_FIFO_FULL = 9;
	localparam int STA_OVERRUN = 10;
	localparam int STA_GLYPH_SEL = 11;
	localparam int STA_LEVEL_LSB = 12;

	// Command fields
	localparam int CMD_CLEAR_BIT = 8;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic strobe;
		logic register_select;
		logic read_not_write;
		logic [7:0] data;
	} host_pins_t;

	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} avalon_req_t;

endpackage : char_lcd_pkg

// *** design/char_lcd_fifo.sv ***
// Small synchronous FIFO held in flip-flops, valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module char_lcd_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} fifo_state_t;

	fifo_state_t s_q;
	fifo_state_t s_d;
	logic push;
	logic pop;

	// ==========================================================
	// Flags
	assign in_ready = (s_q.count != (AW+1)'(DEPTH));
	assign out_valid = (s_q.count != '0);
	assign out_data = s_q.mem[s_q.rd_ptr];
	assign level = s_q.count;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr_ptr] = in_data;
			s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + AW'(1);
		end
		if (pop) begin
			s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + AW'(1);
		end
		if (push && !pop) begin
			s_d.count = s_q.count + (AW+1)'(1);
		end else if (pop && !push) begin
			s_d.count = s_q.count - (AW+1)'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : char_lcd_fifo

// *** verification/char_lcd_host_sva.sv ***
// Checker of pin and register bus timing of the host port.
// Assumes a bind onto char_lcd_host_port; sees its ports only.
`timescale 1ns/10ps
module char_lcd_host_sva
	import char_lcd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire host_pins_t pins,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire avalon_req_t avs_req,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic rq = avs_req.read | avs_req.write;
	bus_ack_a: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer too long");
	ack_cause_a: assert property (!avs_waitrequest |-> $past(rq))
		else $error("bus answer without request");
	oe_rise_a: assert property ($rose(pins.strobe) && pins.read_not_write |=> data_oe)
		else $error("read not driven");
	oe_cause_a: assert property ($rose(data_oe) |-> $past(pins.strobe && pins.read_not_write))
		else $error("drive without read");
	oe_write_a: assert property (pins.strobe && !pins.read_not_write |=> !data_oe)
		else $error("drive during write");
	oe_end_a: assert property ($fell(pins.strobe) |=> !data_oe)
		else $error("drive after strobe");
	out_hold_a: assert property (data_oe && pins.strobe |=> data_oe && $stable(data_out))
		else $error("read data moved");
endmodule : char_lcd_host_sva
bind char_lcd_host_port char_lcd_host_sva chk (.mclk(mclk), .rst_n(rst_n), .pins(pins),
	.data_out(data_out), .data_oe(data_oe), .avs_req(avs_req),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// *** verification/char_lcd_host_model.sv ***
// Host processor model driving the strobed parallel pins.
// Assumes its task is called right after a rising mclk edge.
`timescale 1ns/10ps
module char_lcd_host_model
	import char_lcd_pkg::*;
(
	input wire logic mclk,
	output host_pins_t pins,
	input wire logic [7:0] data_out
);
	// ==========================================================
	// Transfer
	initial pins = '0;
	// Three cycles high and low, above the two-cycle minimum
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
		output logic [7:0] q);
		pins <= '{1'b1, rs, rw, rw ? ~pins.data : d};
		repeat (3) @(posedge mclk);
		q = data_out;
		pins.strobe <= 1'b0;
		@(posedge mclk);
		// Released bus shows no stale value; held through the edge that sees the fall
		pins.data <= ~pins.data;
		repeat (2) @(posedge mclk);
	endtask : xfer
endmodule : char_lcd_host_model

// *** verification/tb_char_lcd_host_bus_port.sv ***
// Self-checking bench of the character display host port.
// Assumes package, design, host model and checker compiled first.
`timescale 1ns/10ps
module tb_char_lcd_host_bus_port;
	import char_lcd_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	host_pins_t pins;
	logic [7:0] data_out;
	logic data_oe;
	avalon_req_t avs_req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [7:0] q;
	logic [31:0] r;
	always #12.5 mclk = ~mclk;
	char_lcd_host_port #(.DEPTH(FIFO_DEPTH)) dut (.mclk(mclk), .rst_n(rst_n), .pins(pins),
		.data_out(data_out), .data_oe(data_oe), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	char_lcd_host_model host (.mclk(mclk), .pins(pins), .data_out(data_out));
	// ==========================================================
	// Helpers
	task automatic report_and_stop;
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] wd);
		avs_req <= '{a, !wr, wr, wd};
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		r = avs_readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
		@(posedge mclk);
	endtask : av
	task automatic wr(input logic rs, input logic [7:0] d);
		host.xfer(rs, 1'b0, d, q);
	endtask : wr
	task automatic rd(input logic rs);
		host.xfer(rs, 1'b1, 8'h00, q);
	endtask : rd
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk("waitrequest", 1, avs_waitrequest);
		chk("data_oe", 0, data_oe);
		av(OFS_CONTROL, 0, 0);
		chk("eight_bit", CTL_EIGHT_BIT_RESET, r[CTL_EIGHT_BIT]);
		av(4'h2, 0, 0);
		chk("unmapped", 0, r);
	endtask : t_reset
	task automatic t_status;
		wr(0, 8'h85);
		rd(0);
		chk("status", 8'h05, q);
	endtask : t_status
	task automatic t_data;
		wr(1, 8'h41);
		wr(0, 8'hA7);
		wr(1, 8'h55);
		rd(0);
		chk("row_wrap", 8'h40, q);
		wr(0, 8'h85);
		rd(1);
		chk("data_read", 8'h41, q);
		av(OFS_PEEK, 1, 32'h27);
		av(OFS_PEEK, 0, 0);
		chk("peek", 32'h2755, r[14:0]);
	endtask : t_data
	task automatic t_glyph;
		wr(0, 8'h40);
		wr(1, 8'h1F);
		av(OFS_STATUS, 0, 0);
		chk("glyph_sel", 1, r[STA_GLYPH_SEL]);
		wr(0, 8'h40);
		rd(1);
		chk("glyph_read", 8'h1F, q);
	endtask : t_glyph
	task automatic t_nibble;
		av(OFS_CONTROL, 1, 32'h2);
		// Lower lines carry junk that must not count
		wr(0, 8'hC5);
		wr(0, 8'h0A);
		wr(1, 8'h39);
		wr(1, 8'hC6);
		wr(0, 8'hCF);
		wr(0, 8'h03);
		rd(1);
		chk("upper_nibble", 8'h30, q);
		rd(1);
		chk("lower_nibble", 8'hC0, q);
		av(OFS_CONTROL, 1, 32'h1);
	endtask : t_nibble
	task automatic t_fifo;
		// Pending command stalls the queue so it fills
		wr(0, 8'h01);
		av(OFS_COMMAND, 0, 0);
		chk("command", 32'h101, r[8:0]);
		wr(0, 8'h02);
		for (int i = 0; i < FIFO_DEPTH + 1; i++) wr(1, 8'h60);
		av(OFS_STATUS, 0, 0);
		chk("queue_full", 7'h43, r[15:9]);
		rd(0);
		chk("busy", 1, q[7]);
		av(OFS_COMMAND, 1, 32'h100);
		av(OFS_STATUS, 0, 0);
		for (int i = 0; i < 20 && r[15:12] !== 4'h0; i++) av(OFS_STATUS, 0, 0);
		av(OFS_COMMAND, 1, 32'h100);
		av(OFS_STATUS, 1, 32'h400);
		av(OFS_STATUS, 0, 0);
		chk("drained", 0, r[15:7]);
	endtask : t_fifo
	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_status();
		t_data();
		t_glyph();
		t_nibble();
		t_fifo();
		report_and_stop();
	end
endmodule : tb_char_lcd_host_bus_port
